// ===== rtl/sbp_consts.svh
// Purpose: timing counts, register offsets and field positions
// Assumes: 25 MHz system clock
// Notes: counts are derived from the times they stand for
`ifndef SBP_CONSTS_SVH
`define SBP_CONSTS_SVH

`define SBP_CLK_KHZ 25000
// longest encoder gap before the motor counts as stopped: 0.7 s
`define SBP_SPD_DOWN_MS 700
`define SBP_SPD_DOWN_CYC (`SBP_SPD_DOWN_MS * `SBP_CLK_KHZ)
// longest bleeder on-time before it is inhibited
`define SBP_BLEED_MAX_MS 50
`define SBP_BLEED_MAX_CYC (`SBP_BLEED_MAX_MS * `SBP_CLK_KHZ)
// triangle wave: 22 kHz target, 510 steps of 2 cycles give a 1020-cycle period (about 24.5 kHz)
`define SBP_TRI_KHZ 22
`define SBP_TRI_PERIOD_CYC (`SBP_CLK_KHZ / `SBP_TRI_KHZ)
`define SBP_TRI_STEPS 510
`define SBP_TRI_STEP_CYC (`SBP_TRI_PERIOD_CYC / `SBP_TRI_STEPS)

`define SBP_ADDR_CTRL 4'h0
`define SBP_ADDR_STATUS 4'h4
`define SBP_ADDR_CMD 4'h8
`define SBP_CTRL_RST 16'h40ff
`define SBP_CTRL_CMD_LSB 0
`define SBP_CTRL_LIM_LSB 8

`define SBP_ST_SPD_DOWN 0
`define SBP_ST_REVERSE 1
`define SBP_ST_MOTOR_OFF 2
`define SBP_ST_CL1 3
`define SBP_ST_CL2 4
`define SBP_ST_OV_POS 5
`define SBP_ST_OV_NEG 6
`define SBP_ST_INH_POS 7
`define SBP_ST_INH_NEG 8
`define SBP_ST_RUN 9
`define SBP_ST_WIDTH 10

// synchroniser reset image: run and current-limit inputs idle high
`define SBP_SYNC_RST 9'h01c

`endif

// ===== rtl/sbp_pkg.sv
// Purpose: shared types of the spindle brake and protection block
// Assumes: nothing
// Notes: constants live in sbp_consts.svh
package sbp_pkg;
  typedef enum logic [1:0] {
    sbp_tri_up = 2'b01,
    sbp_tri_down = 2'b10
  } sbp_tri_dir_e;

  typedef logic [7:0] sbp_mag_t;
endpackage

// ===== rtl/sbp_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs are slow compared with the clock
// Notes: only the second stage is read outside
`timescale 1ns/1ns
module sbp_sync #(
  parameter int WIDTH = 9,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_reg[i] <= RST_VAL[i];
        q_o[i] <= RST_VAL[i];
      end else begin
        meta_reg[i] <= d_i[i];
        q_o[i] <= meta_reg[i];
      end
    end
  end

  a_sync_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i, 2) |-> q_o == $past(d_i, 2))
    else $error("synchroniser output is not input delayed by two");
endmodule

// ===== rtl/sbp_pwm.sv
// Purpose: triangle wave and duty comparator of the current loop
// Assumes: measured current is a sample on the same clock
// Notes: duty grows with the command-minus-measured gap
`timescale 1ns/1ns
`include "sbp_consts.svh"
module sbp_pwm (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire sbp_pkg::sbp_mag_t cmd_i,
  input wire sbp_pkg::sbp_mag_t meas_i,
  output logic duty_o
);
  sbp_pkg::sbp_mag_t err;
  sbp_pkg::sbp_mag_t tri_reg;
  sbp_pkg::sbp_tri_dir_e dir_reg;
  logic [3:0] step_cnt_reg;
  logic step_en;

  always_comb begin
    err = (cmd_i > meas_i) ? cmd_i - meas_i : 8'h00;
  end

  assign step_en = step_cnt_reg == 4'(`SBP_TRI_STEP_CYC - 1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_cnt_reg <= 4'h0;
    end else if (step_en) begin
      step_cnt_reg <= 4'h0;
    end else begin
      step_cnt_reg <= step_cnt_reg + 4'h1;
    end
  end

  // up 255 steps, down 255 steps: one period of 1020 clock cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tri_reg <= 8'h00;
      dir_reg <= sbp_pkg::sbp_tri_up;
    end else if (step_en) begin
      unique case (dir_reg)
        sbp_pkg::sbp_tri_up: begin
          if (tri_reg == 8'hff) begin
            dir_reg <= sbp_pkg::sbp_tri_down;
            tri_reg <= 8'hfe;
          end else begin
            tri_reg <= tri_reg + 8'h01;
          end
        end
        sbp_pkg::sbp_tri_down: begin
          if (tri_reg == 8'h00) begin
            dir_reg <= sbp_pkg::sbp_tri_up;
            tri_reg <= 8'h01;
          end else begin
            tri_reg <= tri_reg - 8'h01;
          end
        end
        default: dir_reg <= sbp_pkg::sbp_tri_up;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_o <= 1'b0;
    end else begin
      duty_o <= err > tri_reg;
    end
  end

  a_pwm_duty: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (err == 8'h00) |=> !duty_o)
    else $error("duty on with no current error");
  a_pwm_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (err > tri_reg) |=> duty_o)
    else $error("duty off while error is above the triangle");
endmodule

// ===== rtl/sbp_spindle_protect.sv
// Purpose: spindle motor braking, stop detection and protection
// Assumes: current sample arrives on clk_i; other inputs are pins
// Notes: current-limit latches clear only on the power-on preset
`timescale 1ns/1ns
`include "sbp_consts.svh"
// Notes on behaviour
// - run inactive inverts encoder phases for braking
// - encoder gap over 0.7 s sets speed-down
// - stopped and not running inhibits both phases
// - phase B leading A with run inactive sets reverse flag, inhibits
// - both inhibited shows motor-off; run clears flags
// - current-limit pin latches, disables its phase only
// - current-limit latch lights fault, requests retract
// - current-limit latches clear only on power-on preset
// - overvoltage turns phases off, enables bleeder
// - drive resumes only below lower voltage threshold
// - excessive bleeder on-time inhibits the bleeder
// - braking limits the spindle current command
// - duty-cycle outputs for positive and negative phases
// - one encoder pulse per edge of either sensor
module sbp_spindle_protect #(
  parameter logic [24:0] SPD_DOWN_CYC = 25'(`SBP_SPD_DOWN_CYC),
  parameter logic [20:0] BLEED_MAX_CYC = 21'(`SBP_BLEED_MAX_CYC)
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic power_on_preset_n_i,
  input wire logic run_spindle_cmd_n_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic phase1_current_limit_n_i,
  input wire logic phase2_current_limit_n_i,
  input wire logic pos_above_upper_i,
  input wire logic pos_below_lower_i,
  input wire logic neg_above_upper_i,
  input wire logic neg_below_lower_i,
  input wire logic [7:0] measured_motor_current_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic sw_ph1_pos_o,
  output logic sw_ph1_neg_o,
  output logic sw_ph2_pos_o,
  output logic sw_ph2_neg_o,
  output logic pwm_pos_n_o,
  output logic pwm_neg_n_o,
  output logic enc_pulse_o,
  output logic speed_down_n_o,
  output logic motor_off_o,
  output logic spindle_fault_indicator_o,
  output logic interlock_fault_o,
  output logic positive_supply_overvolt_o,
  output logic negative_supply_overvolt_o,
  output logic bleed_pos_o,
  output logic bleed_neg_o,
  output logic [7:0] spindle_current_command_o
);
  logic rst_meta, rst_n, por_meta, por_n;
  logic [8:0] raw, syn;
  logic enc_a_s, enc_b_s, run_act;
  logic [1:0] cl_n_s, ov_hi, ov_lo;
  logic enc_a_d, enc_b_d, run_d;
  logic enc_edge, run_rise, enc_pulse, rev_step, both_inh, duty;
  logic [1:0] phase_reg, cl_reg, ov_reg, inh_reg, bleed_reg, en;
  logic [1:0] sw_pos_reg, sw_neg_reg;
  logic [20:0] bleed_cnt [2];
  logic [24:0] spd_cnt;
  logic spd_n_reg, rev_reg, motor_off_reg, enc_pulse_reg;
  logic fault_reg, ilk_reg, pwm_pos_n_reg, pwm_neg_n_reg;
  logic [15:0] ctrl_reg;
  sbp_pkg::sbp_mag_t scc_reg;
  logic [`SBP_ST_WIDTH-1:0] status;

  // reset release through two flops for both reset sources
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge clk_i or negedge power_on_preset_n_i) begin
    if (!power_on_preset_n_i) begin
      por_meta <= 1'b0;
      por_n <= 1'b0;
    end else begin
      por_meta <= 1'b1;
      por_n <= por_meta;
    end
  end

  assign raw = {neg_below_lower_i, neg_above_upper_i, pos_below_lower_i,
                pos_above_upper_i, phase2_current_limit_n_i,
                phase1_current_limit_n_i, run_spindle_cmd_n_i,
                enc_b_i, enc_a_i};

  sbp_sync #(.WIDTH(9), .RST_VAL(`SBP_SYNC_RST)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i(raw),
    .q_o(syn)
  );

  assign enc_a_s = syn[0];
  assign enc_b_s = syn[1];
  assign run_act = ~syn[2];
  assign cl_n_s = syn[4:3];
  assign ov_hi = {syn[7], syn[5]};
  assign ov_lo = {syn[8], syn[6]};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enc_a_d <= 1'b0;
      enc_b_d <= 1'b0;
      run_d <= 1'b0;
    end else begin
      enc_a_d <= enc_a_s;
      enc_b_d <= enc_b_s;
      run_d <= run_act;
    end
  end

  assign enc_edge = (enc_a_s ^ enc_a_d) | (enc_b_s ^ enc_b_d);
  assign run_rise = run_act & ~run_d;
  // a new run command also loads the initial phasing
  assign enc_pulse = enc_edge | run_rise;
  // reverse step: new A equals old B, new B equals old A inverted
  assign rev_step = enc_edge & (enc_a_s == enc_b_d) & (enc_b_s == ~enc_a_d);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 2'b00;
    end else if (enc_pulse) begin
      phase_reg <= {enc_b_s, enc_a_s} ^ {2{~run_act}};
    end
  end

  // stop interval in clock ticks, saturating at the limit
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spd_cnt <= 25'h0;
    end else if (enc_pulse) begin
      spd_cnt <= 25'h0;
    end else if (spd_cnt != SPD_DOWN_CYC) begin
      spd_cnt <= spd_cnt + 25'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spd_n_reg <= 1'b1;
    end else if (spd_cnt == SPD_DOWN_CYC && !enc_pulse) begin
      // a pulse restarts the interval, so a new run can clear it
      spd_n_reg <= 1'b0;
    end else if (run_rise) begin
      spd_n_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rev_reg <= 1'b0;
    end else if (rev_step && !run_act) begin
      rev_reg <= 1'b1;
    end else if (run_rise) begin
      rev_reg <= 1'b0;
    end
  end

  assign both_inh = (~run_act & ~spd_n_reg) | rev_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      motor_off_reg <= 1'b0;
      enc_pulse_reg <= 1'b0;
    end else begin
      motor_off_reg <= both_inh;
      enc_pulse_reg <= enc_pulse;
    end
  end

  for (genvar k = 0; k < 2; k++) begin : g_chan
    // only the power-on preset clears a current-limit latch
    always_ff @(posedge clk_i or negedge por_n) begin
      if (!por_n) begin
        cl_reg[k] <= 1'b0;
      end else if (!cl_n_s[k]) begin
        cl_reg[k] <= 1'b1;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        ov_reg[k] <= 1'b0;
      end else if (ov_hi[k]) begin
        ov_reg[k] <= 1'b1;
      end else if (ov_lo[k]) begin
        ov_reg[k] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        bleed_cnt[k] <= 21'h0;
      end else if (!ov_reg[k]) begin
        bleed_cnt[k] <= 21'h0;
      end else if (!inh_reg[k] && bleed_cnt[k] != BLEED_MAX_CYC) begin
        bleed_cnt[k] <= bleed_cnt[k] + 21'h1;
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        inh_reg[k] <= 1'b0;
      end else if (bleed_cnt[k] == BLEED_MAX_CYC) begin
        inh_reg[k] <= 1'b1;
      end else if (run_rise) begin
        inh_reg[k] <= 1'b0;
      end
    end

    assign en[k] = ~cl_reg[k] & ~both_inh & ~(|ov_reg);

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        bleed_reg[k] <= 1'b0;
        sw_pos_reg[k] <= 1'b0;
        sw_neg_reg[k] <= 1'b0;
      end else begin
        bleed_reg[k] <= ov_reg[k] & ~inh_reg[k];
        sw_pos_reg[k] <= en[k] & phase_reg[k] & duty;
        sw_neg_reg[k] <= en[k] & ~phase_reg[k] & duty;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_reg <= 1'b0;
      ilk_reg <= 1'b0;
      pwm_pos_n_reg <= 1'b1;
      pwm_neg_n_reg <= 1'b1;
    end else begin
      fault_reg <= |cl_reg;
      ilk_reg <= |cl_reg;
      pwm_pos_n_reg <= ~(duty & |(en & phase_reg));
      pwm_neg_n_reg <= ~(duty & |(en & ~phase_reg));
    end
  end

  // braking caps the command at the programmed limit
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scc_reg <= 8'h00;
    end else if (!run_act && ctrl_reg[15:8] < ctrl_reg[7:0]) begin
      scc_reg <= ctrl_reg[15:8];
    end else begin
      scc_reg <= ctrl_reg[7:0];
    end
  end

  sbp_pwm u_pwm (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .cmd_i(scc_reg),
    .meas_i(measured_motor_current_i),
    .duty_o(duty)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= `SBP_CTRL_RST;
    end else if (wr_i && addr_i == `SBP_ADDR_CTRL) begin
      ctrl_reg <= wdata_i[15:0];
    end
  end

  always_comb begin
    status = '0;
    status[`SBP_ST_SPD_DOWN] = ~spd_n_reg;
    status[`SBP_ST_REVERSE] = rev_reg;
    status[`SBP_ST_MOTOR_OFF] = motor_off_reg;
    status[`SBP_ST_CL1] = cl_reg[0];
    status[`SBP_ST_CL2] = cl_reg[1];
    status[`SBP_ST_OV_POS] = ov_reg[0];
    status[`SBP_ST_OV_NEG] = ov_reg[1];
    status[`SBP_ST_INH_POS] = inh_reg[0];
    status[`SBP_ST_INH_NEG] = inh_reg[1];
    status[`SBP_ST_RUN] = run_act;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      unique case (addr_i)
        `SBP_ADDR_CTRL: rdata_o <= {16'h0, ctrl_reg};
        `SBP_ADDR_STATUS: rdata_o <= {22'h0, status};
        `SBP_ADDR_CMD: rdata_o <= {24'h0, scc_reg};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

  assign sw_ph1_pos_o = sw_pos_reg[0];
  assign sw_ph1_neg_o = sw_neg_reg[0];
  assign sw_ph2_pos_o = sw_pos_reg[1];
  assign sw_ph2_neg_o = sw_neg_reg[1];
  assign pwm_pos_n_o = pwm_pos_n_reg;
  assign pwm_neg_n_o = pwm_neg_n_reg;
  assign enc_pulse_o = enc_pulse_reg;
  assign speed_down_n_o = spd_n_reg;
  assign motor_off_o = motor_off_reg;
  assign spindle_fault_indicator_o = fault_reg;
  assign interlock_fault_o = ilk_reg;
  assign positive_supply_overvolt_o = ov_reg[0];
  assign negative_supply_overvolt_o = ov_reg[1];
  assign bleed_pos_o = bleed_reg[0];
  assign bleed_neg_o = bleed_reg[1];
  assign spindle_current_command_o = scc_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_no_drive;
    !(|sw_pos_reg) && !(|sw_neg_reg);
  endsequence
  sequence s_cl1_trip;
    cl_reg[0] ##1 (!sw_pos_reg[0] && !sw_neg_reg[0]);
  endsequence

  a_brake_invert: assert property (
    enc_pulse && !run_act |=> phase_reg == ~$past({enc_b_s, enc_a_s}))
    else $error("encoder phase not inverted while braking");
  a_speed_down_set: assert property (
    spd_cnt == SPD_DOWN_CYC && !enc_pulse |=> !spd_n_reg)
    else $error("speed-down latch missed the interval limit");
  a_stop_inhibit: assert property (
    !run_act && !spd_n_reg |=> s_no_drive)
    else $error("phase driven while stopped and not running");
  a_reverse_flag: assert property (
    rev_step && !run_act |=> rev_reg ##1 (motor_off_reg and s_no_drive))
    else $error("reverse rotation did not inhibit the motor");
  a_motor_off: assert property (
    both_inh |=> motor_off_reg)
    else $error("motor-off indicator missing");
  a_run_clears: assert property (
    run_rise |=> spd_n_reg && !rev_reg)
    else $error("new run command did not clear stop flags");
  a_cl_latch: assert property (disable iff (!por_n || !rst_n)
    !cl_n_s[0] && !(|ov_reg) |=> s_cl1_trip)
    else $error("current limit did not disable its phase");
  a_fault_light: assert property (disable iff (!por_n || !rst_n)
    |cl_reg |=> fault_reg && ilk_reg)
    else $error("fault indicator or interlock not raised");
  a_cl_hold: assert property (disable iff (!por_n)
    cl_reg[1] |=> cl_reg[1])
    else $error("current-limit latch cleared without preset");
  a_ov_gate: assert property (
    |ov_reg |=> s_no_drive)
    else $error("phase driven during overvoltage");
  a_ov_hyst: assert property (
    ov_reg[0] && !ov_lo[0] |=> ov_reg[0])
    else $error("overvoltage released above the lower threshold");
  a_bleed_limit: assert property (
    bleed_cnt[0] == BLEED_MAX_CYC |=> inh_reg[0] ##1 !bleed_reg[0])
    else $error("bleeder not inhibited after its on-time limit");
  a_brake_limit: assert property (
    !run_act |=> scc_reg <= $past(ctrl_reg[15:8]))
    else $error("braking command above the limit");
  a_enc_pulse: assert property (
    enc_edge |=> enc_pulse_o)
    else $error("encoder edge without encoder pulse");
endmodule

// ===== tb/sbp_motor_model.sv
// Purpose: far side of the spindle block: switches, sense, supplies
// Assumes: supply levels are whole volts set by the bench
// Notes: overcurrent only shows on a phase that is switched on
`timescale 1ns/1ns
module sbp_motor_model (
  input wire logic clk_i,
  input wire logic [3:0] sw_i,
  input wire logic [1:0] trip_i,
  input wire logic [5:0] vpos_i,
  input wire logic [5:0] vneg_i,
  input wire logic power_cycle_i,
  input wire logic [7:0] meas_i,
  output logic cl1_n_o,
  output logic cl2_n_o,
  output logic pos_above_o,
  output logic pos_below_o,
  output logic neg_above_o,
  output logic neg_below_o,
  output logic preset_n_o,
  output logic [7:0] meas_o
);
  // sense networks only see current in a driven phase
  always_ff @(posedge clk_i) begin
    cl1_n_o <= !(trip_i[0] && (|sw_i[1:0]));
    cl2_n_o <= !(trip_i[1] && (|sw_i[3:2]));
    meas_o <= meas_i;
  end
  assign pos_above_o = vpos_i > 6'd42;
  assign neg_above_o = vneg_i > 6'd42;
  assign pos_below_o = vpos_i < 6'd40;
  assign neg_below_o = vneg_i < 6'd40;
  // power cycled off and on gives a momentary preset
  assign preset_n_o = !power_cycle_i;
endmodule

// ===== tb/spindle_brake_and_protection_test.sv
// Purpose: self-checking bench of the spindle protection block
// Assumes: stop gap 200 cycles, bleeder limit 50 cycles
// Notes: register reads are checked from a queue of expectations
`timescale 1ns/1ns
module spindle_brake_and_protection_test;
  `define CHK(g, e) begin cmp_count++; \
    if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clk_i = 0, rstn_i = 0, run_n = 1, ea = 0, eb = 0;
  logic wr = 0, rd = 0, pcyc = 1, pend = 0;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0;
  logic [1:0] trip = 0;
  logic [5:0] vpos = 36, vneg = 36;
  logic [7:0] meas = 0, meas_w, cmdo;
  logic preset_n, cl1_n, cl2_n, pa, pb, na, nb;
  logic pwm_p, pwm_n, encp, spd_n, moff, flt, ilk;
  logic [31:0] rdata;
  logic [3:0] sw, seen;
  logic [1:0] ov, bl;
  logic [31:0] exp_q[$], msk_q[$];
  logic [1:0] fwd[4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int fail_count = 0, cmp_count = 0, npulse = 0, n0, gap;
  int lo[3];

  sbp_spindle_protect #(.SPD_DOWN_CYC(25'd200), .BLEED_MAX_CYC(21'd50)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .power_on_preset_n_i(preset_n),
    .run_spindle_cmd_n_i(run_n), .enc_a_i(ea), .enc_b_i(eb),
    .phase1_current_limit_n_i(cl1_n), .phase2_current_limit_n_i(cl2_n),
    .pos_above_upper_i(pa), .pos_below_lower_i(pb),
    .neg_above_upper_i(na), .neg_below_lower_i(nb),
    .measured_motor_current_i(meas_w), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .sw_ph1_pos_o(sw[0]), .sw_ph1_neg_o(sw[1]),
    .sw_ph2_pos_o(sw[2]), .sw_ph2_neg_o(sw[3]),
    .pwm_pos_n_o(pwm_p), .pwm_neg_n_o(pwm_n), .enc_pulse_o(encp),
    .speed_down_n_o(spd_n), .motor_off_o(moff),
    .spindle_fault_indicator_o(flt), .interlock_fault_o(ilk),
    .positive_supply_overvolt_o(ov[0]), .negative_supply_overvolt_o(ov[1]),
    .bleed_pos_o(bl[0]), .bleed_neg_o(bl[1]),
    .spindle_current_command_o(cmdo));

  sbp_motor_model far (
    .clk_i(clk_i), .sw_i(sw), .trip_i(trip), .vpos_i(vpos), .vneg_i(vneg),
    .power_cycle_i(pcyc), .meas_i(meas), .cl1_n_o(cl1_n), .cl2_n_o(cl2_n),
    .pos_above_o(pa), .pos_below_o(pb), .neg_above_o(na),
    .neg_below_o(nb), .preset_n_o(preset_n), .meas_o(meas_w));

  always #20 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (encp === 1'b1) npulse++;
  end

  // read data stand in the cycle after the strobe only
  always @(posedge clk_i) begin
    if (pend) begin
      `CHK(rdata & msk_q[0], exp_q[0])
      void'(msk_q.pop_front());
      void'(exp_q.pop_front());
    end
    pend <= rd;
  end

  task automatic tick(int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic rdc(logic [3:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clk_i);
    rd <= 1;
    addr <= a;
    msk_q.push_back(m);
    exp_q.push_back(e);
    @(posedge clk_i);
    rd <= 0;
  endtask

  task automatic wrc(logic [3:0] a, logic [31:0] d);
    @(posedge clk_i);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk_i);
    wr <= 0;
  endtask

  // switches pulse with the duty: collect them over four cycles
  task automatic watch();
    seen = 4'h0;
    repeat (4) begin
      @(posedge clk_i);
      seen = seen | sw;
    end
  endtask

  task automatic enc(logic a, logic b);
    @(posedge clk_i);
    ea <= a;
    eb <= b;
    tick(5);
    watch();
  endtask

  task automatic run(logic v);
    @(posedge clk_i);
    run_n <= v;
    tick(8);
  endtask

  task automatic setv(int i, logic [5:0] v);
    @(posedge clk_i);
    if (i == 0) vpos <= v;
    else vneg <= v;
    tick(8);
  endtask

  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    fail_count++;
    close_out();
  end

  initial begin
    void'($urandom(32'h857e));
    tick(3);
    `CHK({pwm_p, spd_n, moff}, 3'b110)
    repeat (5) @(posedge clk_i);
    rstn_i <= 1;
    pcyc <= 0;
    tick(4);
    rdc(4'h0, '1, 32'h40ff);
    rdc(4'h8, '1, 32'h40);
    rdc(4'hc, '1, 32'h0);
    wrc(4'h4, '1);
    tick(80);
    `CHK(spd_n, 1'b1)
    tick(200);
    `CHK(spd_n, 1'b0)
    `CHK(moff, 1'b1)
    `CHK(sw, 4'h0)
    rdc(4'h4, 32'h5, 32'h5);
    run(0);
    rdc(4'h4, 32'h207, 32'h200);
    rdc(4'h8, '1, 32'hff);
    n0 = npulse;
    for (int k = 0; k < 4; k++) begin
      enc(fwd[k][1], fwd[k][0]);
      `CHK(seen, {~eb, eb, ~ea, ea})
    end
    `CHK(npulse - n0, 4)
    wrc(4'h0, 32'hffff);
    run(1);
    for (int k = 0; k < 4; k++) begin
      enc(fwd[k][1], fwd[k][0]);
      `CHK(seen, {eb, ~eb, ea, ~ea})
    end
    wrc(4'h0, 32'h3080);
    rdc(4'h8, '1, 32'h30);
    wrc(4'h0, 32'h3020);
    rdc(4'h8, '1, 32'h20);
    tick(300);
    `CHK({moff, sw}, 5'h10)
    run(0);
    run(1);
    rdc(4'h4, 32'h2, 32'h0);
    enc(1'b0, 1'b1);
    rdc(4'h4, 32'h2, 32'h2);
    `CHK({moff, sw}, 5'h10)
    run(0);
    rdc(4'h4, 32'h7, 32'h0);
    `CHK(moff, 1'b0)
    wrc(4'h0, 32'h40ff);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      trip[i] <= 1;
      tick(8);
      trip <= 0;
      rdc(4'h4, 32'h8 << i, 32'h8 << i);
      `CHK({flt, ilk}, 2'b11)
      watch();
      `CHK(seen[2 * i +: 2], 2'b00)
      `CHK(|seen[2 * (1 - i) +: 2], 1'b1)
      @(posedge clk_i);
      rstn_i <= 0;
      tick(2);
      rstn_i <= 1;
      tick(10);
      rdc(4'h4, 32'h8 << i, 32'h8 << i);
      @(posedge clk_i);
      pcyc <= 1;
      tick(2);
      pcyc <= 0;
      tick(6);
      rdc(4'h4, 32'h18, 32'h0);
      `CHK(flt, 1'b0)
    end
    for (int i = 0; i < 2; i++) begin
      setv(i, 45);
      `CHK({ov[i], bl[i], sw}, 6'h30)
      setv(i, 41);
      `CHK(ov[i], 1'b1)
      setv(i, 38);
      watch();
      `CHK({ov[i], |seen}, 2'b01)
      setv(i, 50);
      tick(80);
      `CHK(bl[i], 1'b0)
      rdc(4'h4, 32'h80 << i, 32'h80 << i);
      setv(i, 36);
      run(1);
      run(0);
    end
    wrc(4'h0, 32'h4080);
    for (int k = 0; k < 3; k++) begin
      gap = (k == 0) ? 0 : (k == 1) ? 10 + $urandom % 30 : 100 + $urandom % 27;
      @(posedge clk_i);
      meas <= 8'(8'h80 - gap);
      tick(8);
      lo[k] = 0;
      repeat (1020) begin
        @(posedge clk_i);
        if (pwm_p === 1'b0 || pwm_n === 1'b0) lo[k]++;
      end
    end
    `CHK(lo[0], 0)
    `CHK(lo[1] > 0, 1'b1)
    `CHK(lo[2] > lo[1], 1'b1)
    tick(4);
    close_out();
  end
endmodule
